/* File: hw/nfh_consts.svh */
// Constants of the NAND flash host controller
`ifndef NFH_CONSTS_SVH
`define NFH_CONSTS_SVH
`define NFH_CMD_READ_SETUP 8'h00
`define NFH_CMD_READ_CONFIRM 8'h30
`define NFH_CMD_PROG_SETUP 8'h80
`define NFH_CMD_PROG_CONFIRM 8'h10
`define NFH_CMD_ERASE_SETUP 8'h60
`define NFH_CMD_ERASE_CONFIRM 8'hD0
`define NFH_CMD_RESET 8'hFF
`define NFH_CMD_STATUS 8'h70
`define NFH_CLK_MHZ 20
`define NFH_PROG_BUSY_US 200
`define NFH_ERASE_BUSY_US 1500
`define NFH_PROG_BUSY_CYC (`NFH_PROG_BUSY_US * `NFH_CLK_MHZ)
`define NFH_ERASE_BUSY_CYC (`NFH_ERASE_BUSY_US * `NFH_CLK_MHZ)
`define NFH_STROBE_CYC 2
`define NFH_COL_HI_MASK 8'h0F
`endif

/* File: hw/nfh_host.sv */
// Host-side controller that drives a NAND flash over its pins
//
// How it works
// - Command bytes sent with command_latch high.
// - Address bytes sent with address_latch high.
// - Address: two column then two row bytes.
// - Second column byte upper bits low.
// - Read 00/30, program 80/10, erase 60/D0.
// - Erase sends only two row bytes.
`timescale 1ns/1ps
`include "nfh_consts.svh"
module nfh_host (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Request
  input wire logic req_valid,
  output logic req_ready,
  input wire nfh_pkg::nfh_op_t req_op,
  input wire logic [11:0] req_col,
  input wire logic [15:0] req_row,
  input wire logic [11:0] req_len,
  input wire logic req_abort,
  // Write data from user
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  // Read data to user
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  // Status
  output logic busy,
  output logic timeout,
  // Flash pins
  output logic chip_select_n,
  output logic command_latch,
  output logic address_latch,
  output logic write_strobe_n,
  output logic output_strobe_n,
  output logic program_guard_n,
  input wire logic ready_busy_n,
  input wire logic [7:0] shared_bus_in,
  output logic [7:0] shared_bus_out,
  output logic shared_bus_oe
);
  nfh_pkg::nfh_state_t st_q, st_d;
  nfh_pkg::nfh_op_t op_q, op_d;
  logic [7:0] addr_q [4];
  logic [7:0] addr_d [4];
  logic [1:0] aidx_q, aidx_d;
  logic [11:0] len_q, len_d;
  logic [1:0] ph_q, ph_d;
  logic [15:0] wait_q, wait_d;
  logic timeout_q, timeout_d;
  logic cle_q, cle_d, ale_q, ale_d, we_q, we_d, re_q, re_d, oe_q, oe_d, cs_q, cs_d;
  logic [7:0] dout_q, dout_d;
  logic buf_valid, buf_ready;

  // Confirm code for each two-cycle operation
  function automatic logic [7:0] nfh_confirm(input nfh_pkg::nfh_op_t op);
    case (op)
      nfh_pkg::NFH_OP_READ: nfh_confirm = `NFH_CMD_READ_CONFIRM;
      nfh_pkg::NFH_OP_PROG: nfh_confirm = `NFH_CMD_PROG_CONFIRM;
      default: nfh_confirm = `NFH_CMD_ERASE_CONFIRM;
    endcase
  endfunction : nfh_confirm

  function automatic logic [7:0] nfh_setup(input nfh_pkg::nfh_op_t op);
    case (op)
      nfh_pkg::NFH_OP_READ: nfh_setup = `NFH_CMD_READ_SETUP;
      nfh_pkg::NFH_OP_PROG: nfh_setup = `NFH_CMD_PROG_SETUP;
      nfh_pkg::NFH_OP_ERASE: nfh_setup = `NFH_CMD_ERASE_SETUP;
      default: nfh_setup = `NFH_CMD_STATUS;
    endcase
  endfunction : nfh_setup

  nfh_skid nfh_skid_i (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_valid(buf_valid),
    .in_ready(buf_ready),
    .in_data(shared_bus_in),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign req_ready = (st_q == nfh_pkg::NFH_IDLE);
  assign wr_ready = (st_q == nfh_pkg::NFH_WDATA) && (ph_q == 2'h0);
  // Sample read byte at end of output strobe low phase
  assign buf_valid = (st_q == nfh_pkg::NFH_RDATA) && (ph_q == 2'h1);
  assign busy = (st_q != nfh_pkg::NFH_IDLE);
  assign timeout = timeout_q;
  assign chip_select_n = cs_q;
  assign command_latch = cle_q;
  assign address_latch = ale_q;
  assign write_strobe_n = we_q;
  assign output_strobe_n = re_q;
  assign shared_bus_out = dout_q;
  assign shared_bus_oe = oe_q;
  // Guard released as soon as the controller leaves reset
  assign program_guard_n = reset_n;

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    addr_d = addr_q;
    aidx_d = aidx_q;
    len_d = len_q;
    ph_d = ph_q;
    wait_d = wait_q;
    timeout_d = timeout_q;
    cle_d = cle_q;
    ale_d = ale_q;
    we_d = we_q;
    re_d = 1'b1;
    oe_d = oe_q;
    cs_d = cs_q;
    dout_d = dout_q;
    case (st_q)
      nfh_pkg::NFH_IDLE: begin
        cs_d = 1'b1;
        oe_d = 1'b0;
        we_d = 1'b1;
        cle_d = 1'b0;
        ale_d = 1'b0;
        if (req_valid) begin
          // A reset command is followed by no data phase
          op_d = req_abort ? nfh_pkg::NFH_OP_STATUS : req_op;
          timeout_d = 1'b0;
          addr_d[0] = req_col[7:0];
          addr_d[1] = {4'h0, req_col[11:8]} & `NFH_COL_HI_MASK;
          addr_d[2] = req_row[7:0];
          addr_d[3] = req_row[15:8];
          // Erase skips the column bytes
          aidx_d = (req_op == nfh_pkg::NFH_OP_ERASE) ? 2'h2 : 2'h0;
          len_d = req_len;
          ph_d = 2'h0;
          cs_d = 1'b0;
          dout_d = req_abort ? `NFH_CMD_RESET : nfh_setup(req_op);
          st_d = req_abort ? nfh_pkg::NFH_RESET : nfh_pkg::NFH_CMD1;
        end
      end
      nfh_pkg::NFH_CMD1, nfh_pkg::NFH_CMD2, nfh_pkg::NFH_RESET, nfh_pkg::NFH_ADDR,
      nfh_pkg::NFH_WDATA: begin
        // Phase 0: present byte with strobe low; phase 1: raise strobe
        if (ph_q == 2'h0) begin
          if (st_q != nfh_pkg::NFH_WDATA || wr_valid) begin
            // Byte changes with the falling strobe so it holds across the rise
            case (st_q)
              nfh_pkg::NFH_WDATA: dout_d = wr_data;
              nfh_pkg::NFH_ADDR: dout_d = addr_q[aidx_q];
              nfh_pkg::NFH_CMD2: dout_d = nfh_confirm(op_q);
              default: dout_d = dout_q;
            endcase
            cle_d = (st_q == nfh_pkg::NFH_CMD1) || (st_q == nfh_pkg::NFH_CMD2) ||
                    (st_q == nfh_pkg::NFH_RESET);
            ale_d = (st_q == nfh_pkg::NFH_ADDR);
            oe_d = 1'b1;
            we_d = 1'b0;
            ph_d = 2'h1;
          end
        end else begin
          we_d = 1'b1;
          ph_d = 2'h0;
          case (st_q)
            nfh_pkg::NFH_CMD1: begin
              if (op_q == nfh_pkg::NFH_OP_STATUS) begin
                st_d = nfh_pkg::NFH_RDATA;
                len_d = 12'h001;
              end else begin
                st_d = nfh_pkg::NFH_ADDR;
              end
            end
            nfh_pkg::NFH_ADDR: begin
              // Exactly the required count, never surplus
              if (aidx_q == 2'h3) begin
                st_d = (op_q == nfh_pkg::NFH_OP_PROG) ? nfh_pkg::NFH_WDATA : nfh_pkg::NFH_CMD2;
              end else begin
                aidx_d = aidx_q + 2'h1;
              end
            end
            nfh_pkg::NFH_WDATA: begin
              len_d = len_q - 12'h001;
              if (len_q == 12'h001) begin
                st_d = nfh_pkg::NFH_CMD2;
              end
            end
            default: begin
              st_d = nfh_pkg::NFH_BUSY;
              wait_d = 16'h0000;
            end
          endcase
        end
      end
      nfh_pkg::NFH_BUSY: begin
        // Device works alone; watch ready_busy_n, give up with timeout once wait_q bit 15 sets
        cle_d = 1'b0;
        oe_d = 1'b0;
        ph_d = 2'h0;
        wait_d = wait_q + 16'h0001;
        if (wait_q[15]) begin
          timeout_d = 1'b1;
        end
        if (wait_q >= 16'h0002 && ready_busy_n) begin
          st_d = (op_q == nfh_pkg::NFH_OP_READ) ? nfh_pkg::NFH_RDATA : nfh_pkg::NFH_IDLE;
        end else if (wait_q[15]) begin
          st_d = nfh_pkg::NFH_IDLE;
        end
      end
      nfh_pkg::NFH_RDATA: begin
        oe_d = 1'b0;
        cle_d = 1'b0;
        ale_d = 1'b0;
        if (len_q == 12'h000) begin
          st_d = nfh_pkg::NFH_IDLE;
        end else if (ph_q == 2'h0) begin
          if (buf_ready) begin
            re_d = 1'b0;
            ph_d = 2'h1;
          end
        end else begin
          ph_d = 2'h0;
          len_d = len_q - 12'h001;
        end
      end
      default: st_d = nfh_pkg::NFH_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= nfh_pkg::NFH_IDLE;
      op_q <= nfh_pkg::NFH_OP_READ;
      for (int i = 0; i < 4; i++) begin
        addr_q[i] <= 8'h00;
      end
      aidx_q <= 2'h0;
      len_q <= 12'h000;
      ph_q <= 2'h0;
      wait_q <= 16'h0000;
      timeout_q <= 1'b0;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      we_q <= 1'b1;
      re_q <= 1'b1;
      oe_q <= 1'b0;
      cs_q <= 1'b1;
      dout_q <= 8'h00;
    end else if (clk_en) begin
      st_q <= st_d;
      op_q <= op_d;
      addr_q <= addr_d;
      aidx_q <= aidx_d;
      len_q <= len_d;
      ph_q <= ph_d;
      wait_q <= wait_d;
      timeout_q <= timeout_d;
      cle_q <= cle_d;
      ale_q <= ale_d;
      we_q <= we_d;
      re_q <= re_d;
      oe_q <= oe_d;
      cs_q <= cs_d;
      dout_q <= dout_d;
    end
  end
endmodule : nfh_host

/* File: hw/nfh_pkg.sv */
// Types of the NAND flash host controller
package nfh_pkg;
  typedef enum logic [1:0] {
    NFH_OP_READ = 2'b00,
    NFH_OP_PROG = 2'b01,
    NFH_OP_ERASE = 2'b10,
    NFH_OP_STATUS = 2'b11
  } nfh_op_t;
  typedef enum logic [3:0] {
    NFH_IDLE = 4'b0000,
    NFH_CMD1 = 4'b0001,
    NFH_ADDR = 4'b0010,
    NFH_WDATA = 4'b0011,
    NFH_CMD2 = 4'b0100,
    NFH_BUSY = 4'b0101,
    NFH_RDATA = 4'b0110,
    NFH_RESET = 4'b0111
  } nfh_state_t;
endpackage : nfh_pkg

/* File: hw/nfh_skid.sv */
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module nfh_skid (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);
  logic [7:0] mem_q [2];
  logic [7:0] mem_d [2];
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (clk_en) begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : nfh_skid

/* File: verification/nfh_flash_model.sv */
// Behavioural model of the flash device on the far side of the pins
`timescale 1ns/1ps
module nfh_flash_model #(
  parameter int RD_NS = 25000,
  parameter int PROG_NS = 200000,
  parameter int ERASE_NS = 1500000
) (
  // Host pins
  input wire logic chip_select_n,
  input wire logic command_latch,
  input wire logic address_latch,
  input wire logic write_strobe_n,
  input wire logic output_strobe_n,
  input wire logic program_guard_n,
  input wire logic [7:0] shared_bus_out,
  input wire logic shared_bus_oe,
  // Device outputs
  output logic ready_busy_n,
  output logic [7:0] shared_bus_in
);
  logic [7:0] lc = 8'hFF;
  logic [7:0] dq = 8'h00;
  logic [7:0] ab [4];
  logic [7:0] db [4];
  logic [11:0] col = 12'h000;
  int na = 0;
  int nd = 0;
  initial ready_busy_n = 1'b1;
  // Released bus shows the inverse of the last byte
  assign shared_bus_in = shared_bus_oe ? shared_bus_out :
    (!chip_select_n && !output_strobe_n) ? dq : ~dq;
  always @(posedge write_strobe_n) if (!chip_select_n) begin
    if (command_latch) begin
      lc = shared_bus_out;
      case (lc)
        8'h00, 8'h80, 8'h60: begin
          na = 0;
          nd = 0;
        end
        8'h30: begin
          col = {ab[1][3:0], ab[0]};
          ready_busy_n <= #1 1'b0;
          // Off the clock edge so the host samples it without a race
          ready_busy_n <= #(RD_NS + 1) 1'b1;
        end
        // Busy runs on regardless of chip select
        8'h10, 8'hD0: if (program_guard_n) begin
          ready_busy_n <= #1 1'b0;
          ready_busy_n <= #((lc == 8'h10 ? PROG_NS : ERASE_NS) + 1) 1'b1;
        end
        8'hFF: ready_busy_n <= #1 1'b1;
        default: ;
      endcase
    end else if (address_latch) begin
      if (na < 4) ab[na] = shared_bus_out;
      na = na + 1;
    end else begin
      if (nd < 4) db[nd] = shared_bus_out;
      nd = nd + 1;
    end
  end
  always @(negedge output_strobe_n) if (!chip_select_n) begin
    if (lc == 8'h70) dq = {program_guard_n, ready_busy_n, 6'h00};
    else begin
      dq = col[7:0] ^ ab[2] ^ 8'hA5;
      col = col + 12'h001;
    end
  end
endmodule : nfh_flash_model

/* File: verification/nfh_host_asserts.sv */
// Pin-level assertions of the NAND flash host controller
`timescale 1ns/1ps
`include "nfh_consts.svh"
module nfh_host_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Flash pins
  input wire logic command_latch,
  input wire logic address_latch,
  input wire logic write_strobe_n,
  input wire logic chip_select_n,
  input wire logic [7:0] shared_bus_out,
  input wire logic shared_bus_oe
);
  logic [2:0] na_q, na_d;
  logic er_q, er_d;
  wire cmd_w = command_latch && !write_strobe_n;
  wire adr_w = address_latch && !write_strobe_n;
  // Address bytes since the last command, and whether that command was an erase
  always_comb begin
    na_d = cmd_w ? 3'h0 : na_q + 3'(adr_w);
    er_d = cmd_w ? (shared_bus_out == `NFH_CMD_ERASE_SETUP) : er_q;
  end
  always_ff @(posedge clk) begin
    na_q <= reset_n ? na_d : 3'h0;
    er_q <= reset_n ? er_d : 1'b0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_cmd_strobe_ok: assert property (cmd_w |-> shared_bus_oe && !chip_select_n ##1 write_strobe_n)
    else $error("command strobe malformed");
  a_addr_strobe_ok: assert property (adr_w |-> shared_bus_oe && !command_latch ##1 write_strobe_n)
    else $error("address strobe malformed");
  a_latch_held_rise: assert property ($rose(write_strobe_n) |-> $stable(shared_bus_out)
    && $stable(command_latch) && $stable(address_latch))
    else $error("bus or latch moved at strobe rise");
  a_cmd_code_known: assert property (cmd_w |-> shared_bus_out inside {8'h00, 8'h30, 8'h80,
    8'h10, 8'h60, 8'hD0, 8'hFF, 8'h70})
    else $error("unknown command code");
  a_col_hi_zero: assert property (adr_w && na_q == 3'h1 && !er_q |->
    (shared_bus_out & ~`NFH_COL_HI_MASK) == 8'h00)
    else $error("upper column bits not low");
  a_four_addr_bytes: assert property (cmd_w && shared_bus_out inside {8'h30, 8'h10} |->
    na_q == 3'h4)
    else $error("confirm without four address bytes");
  a_erase_two_rows: assert property (cmd_w && shared_bus_out == 8'hD0 |-> na_q == 3'h2)
    else $error("erase without two row bytes");
  c_read: cover property (cmd_w && shared_bus_out == `NFH_CMD_READ_CONFIRM);
  c_prog: cover property (cmd_w && shared_bus_out == `NFH_CMD_PROG_CONFIRM);
  c_erase: cover property (cmd_w && shared_bus_out == `NFH_CMD_ERASE_CONFIRM);
endmodule : nfh_host_asserts

bind nfh_host nfh_host_asserts nfh_host_asserts_i (.clk, .reset_n, .command_latch,
  .address_latch, .write_strobe_n, .chip_select_n, .shared_bus_out, .shared_bus_oe);

/* File: verification/tb_nfh_host.sv */
// Self-checking testbench of the NAND flash host controller
`timescale 1ns/1ps
module tb_nfh_host;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0, req_abort = 1'b0, wr_valid = 1'b0, rd_ready = 1'b0;
  nfh_pkg::nfh_op_t req_op = nfh_pkg::NFH_OP_READ;
  logic [11:0] req_col = 12'h000, req_len = 12'h001;
  logic [15:0] req_row = 16'h0000;
  logic [7:0] wr_data = 8'h00;
  logic req_ready, wr_ready, rd_valid, busy, timeout, chip_select_n, command_latch;
  logic address_latch, write_strobe_n, output_strobe_n, program_guard_n, ready_busy_n;
  logic shared_bus_oe;
  logic [7:0] rd_data, shared_bus_in, shared_bus_out;
  int n_mismatch = 0;
  int total_checks = 0;
  int n;
  always #25 clk = ~clk;
  nfh_host nfh_host_i (.clk, .reset_n, .clk_en, .req_valid, .req_ready, .req_op, .req_col,
    .req_row, .req_len, .req_abort, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready,
    .rd_data, .busy, .timeout, .chip_select_n, .command_latch, .address_latch, .write_strobe_n,
    .output_strobe_n, .program_guard_n, .ready_busy_n, .shared_bus_in, .shared_bus_out,
    .shared_bus_oe);
  nfh_flash_model nfh_flash_model_i (.chip_select_n, .command_latch, .address_latch,
    .write_strobe_n, .output_strobe_n, .program_guard_n, .shared_bus_out, .shared_bus_oe,
    .ready_busy_n, .shared_bus_in);
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic start(input nfh_pkg::nfh_op_t op, input logic [11:0] col,
      input logic [15:0] row, input logic [11:0] len);
    req_op <= op;
    req_col <= col;
    req_row <= row;
    req_len <= len;
    req_valid <= 1'b1;
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    req_abort <= 1'b0;
  endtask : start
  task automatic idle(output int cyc);
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (busy !== 1'b0);
    @(posedge clk);
  endtask : idle
  task automatic put(input logic [7:0] d);
    wr_data <= d;
    wr_valid <= 1'b1;
    do @(negedge clk); while (wr_ready !== 1'b1);
    @(posedge clk);
  endtask : put
  // Expected byte is the model's pattern of column and row
  task automatic get(input int cnt, input logic [11:0] col, input logic [7:0] row);
    rd_ready <= 1'b1;
    for (int i = 0; i < cnt; i++) begin
      do @(negedge clk); while (rd_valid !== 1'b1);
      chk("rd_data", {8'h00, (col[7:0] + 8'(i)) ^ row ^ 8'hA5}, {8'h00, rd_data});
      @(posedge clk);
    end
    rd_ready <= 1'b0;
  endtask : get
  task automatic addr(input logic [15:0] col, input logic [15:0] row);
    chk("col", col, {nfh_flash_model_i.ab[1], nfh_flash_model_i.ab[0]});
    chk("row", row, {nfh_flash_model_i.ab[3], nfh_flash_model_i.ab[2]});
  endtask : addr
  // Receiver stalls until the buffer is full, column crosses a byte boundary
  task automatic t_read;
    start(nfh_pkg::NFH_OP_READ, 12'h7FE, 16'h1234, 12'h005);
    do @(negedge clk); while (rd_valid !== 1'b1);
    repeat (30) @(posedge clk);
    get(5, 12'h7FE, 8'h34);
    idle(n);
    addr(16'h07FE, 16'h1234);
    chk("cmd", 16'h0030, {8'h00, nfh_flash_model_i.lc});
  endtask : t_read
  task automatic t_prog;
    start(nfh_pkg::NFH_OP_PROG, 12'hA05, 16'hBEEF, 12'h002);
    put(8'h5A);
    put(8'hC3);
    wr_valid <= 1'b0;
    idle(n);
    chk("data", 16'h5AC3, {nfh_flash_model_i.db[0], nfh_flash_model_i.db[1]});
    addr(16'h0A05, 16'hBEEF);
    chk("prog_wait", 16'h0001, {15'h0000, n >= 4000});
    chk("guard", 16'h0001, {15'h0000, program_guard_n});
  endtask : t_prog
  task automatic t_erase;
    start(nfh_pkg::NFH_OP_ERASE, 12'h000, 16'h0A0B, 12'h001);
    idle(n);
    chk("row", 16'h0A0B, {nfh_flash_model_i.ab[1], nfh_flash_model_i.ab[0]});
    chk("n_addr", 16'h0002, nfh_flash_model_i.na[15:0]);
    chk("erase_wait", 16'h0001, {15'h0000, n >= 30000});
    chk("timeout", 16'h0000, {15'h0000, timeout});
  endtask : t_erase
  // Row chosen so that the pattern equals the ready status byte
  // A frozen clock enable must hold off the pending request first
  task automatic t_status;
    clk_en <= 1'b0;
    req_op <= nfh_pkg::NFH_OP_STATUS;
    req_valid <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("frozen", 16'h0001, {14'h0000, busy, write_strobe_n});
    @(posedge clk);
    clk_en <= 1'b1;
    start(nfh_pkg::NFH_OP_STATUS, 12'h000, 16'h0000, 12'h001);
    get(1, 12'h000, 8'h65);
    idle(n);
  endtask : t_status
  task automatic t_abort;
    req_abort <= 1'b1;
    start(nfh_pkg::NFH_OP_READ, 12'h000, 16'h0001, 12'h001);
    idle(n);
    chk("cmd", 16'h00FF, {8'h00, nfh_flash_model_i.lc});
    chk("no_data", 16'h0000, {15'h0000, rd_valid});
  endtask : t_abort
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_read;
    t_prog;
    t_erase;
    t_status;
    t_abort;
    end_of_test;
  end
  initial begin
    #(60000 * 50);
    n_mismatch++;
    end_of_test;
  end
endmodule : tb_nfh_host
